// ---- hdl/glitch_filter.sv ----
`timescale 1ns/1ps
module glitch_filter #(
    parameter int unsigned LOW_CYC = 5
) (
    input wire logic i_clk,
    input wire logic i_rstn,
    input wire logic i_raw,
    output logic o_clean
);
    logic [7:0] cnt_q;
    logic [7:0] cnt_d;
    logic clean_q;
    logic clean_d;

    // a low is only believed after LOW_CYC steady cycles; rises pass fast
    always_comb
    begin
        cnt_d = cnt_q;
        clean_d = clean_q;
        if (i_raw)
        begin
            cnt_d = 8'h00;
            clean_d = 1'b1;
        end
        else if (cnt_q >= 8'(LOW_CYC))
        begin
            clean_d = 1'b0;
        end
        else
        begin
            cnt_d = cnt_q + 8'h01;
        end
    end

    always_ff @(posedge i_clk or negedge i_rstn)
    begin
        if (!i_rstn)
        begin
            cnt_q <= 8'h00;
            clean_q <= 1'b1;
        end
        else
        begin
            cnt_q <= cnt_d;
            clean_q <= clean_d;
        end
    end

    assign o_clean = clean_q;
endmodule : glitch_filter

// ---- hdl/pulse_link_if.sv ----
`timescale 1ns/1ps
interface pulse_link_if;
    logic line_o;
    logic line_oe;
    logic enable;
    logic line;
    // the device never drives: the wire is the master's drive, pulled high when released
    assign line = line_oe ? line_o : 1'b1;
    modport master (output line_o, output line_oe, output enable);
    modport device (input line, input enable);
endinterface : pulse_link_if

// ---- hdl/pulse_sel_device.sv ----
`timescale 1ns/1ps
module pulse_sel_device #(
    parameter int unsigned NEG_DELAY = pulse_sel_pkg::NEG_DELAY_CYC,
    parameter int unsigned REG_DELAY = pulse_sel_pkg::REG_DELAY_CYC
) (
    input wire logic i_clk,
    input wire logic i_rstn,
    pulse_link_if.device link,
    output logic o_device_on,
    output logic o_pos_soft_start,
    output logic o_neg_soft_start,
    output logic o_regulating,
    output logic [4:0] o_level_code,
    output logic [12:0] o_negative_rail_level
);
    // ****************************************************************
    // types and helpers
    // ****************************************************************
    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_START = 2'b01,
        ST_COUNT = 2'b10
    } rx_state_t;

    function automatic logic [12:0] level_mv(input logic [4:0] n);
        level_mv = pulse_sel_pkg::LEVEL_BASE_MV
            - 13'(({8'h00, n} - 13'h0001) * pulse_sel_pkg::LEVEL_STEP_MV);
    endfunction : level_mv

    // ****************************************************************
    // line filter
    // ****************************************************************
    logic line_f;
    glitch_filter #(
        .LOW_CYC(pulse_sel_pkg::GLITCH_CYC)
    ) u_filt (
        .i_clk(i_clk),
        .i_rstn(i_rstn),
        .i_raw(link.line),
        .o_clean(line_f)
    );

    // ****************************************************************
    // receiver: no clock from the master, all timing counted here
    // ****************************************************************
    rx_state_t st_q;
    rx_state_t st_d;
    logic line_q;
    logic line_d;
    logic [5:0] cnt_q;
    logic [5:0] cnt_d;
    logic [15:0] tim_q;
    logic [15:0] tim_d;
    logic [4:0] prog_q;
    logic [4:0] prog_d;
    logic prog_ok_q;
    logic prog_ok_d;

    always_comb
    begin
        st_d = st_q;
        line_d = line_f;
        cnt_d = cnt_q;
        tim_d = (line_f == line_q) ? tim_q + 16'h0001 : 16'h0000;
        prog_d = prog_q;
        prog_ok_d = prog_ok_q;
        if (link.enable)
        begin
            // enable high ignores the wire entirely
            st_d = ST_IDLE;
            cnt_d = 6'h00;
        end
        else
        begin
            case (st_q)
                ST_IDLE:
                begin
                    if (!line_f)
                    begin
                        st_d = ST_START;
                    end
                end
                ST_START:
                begin
                    // start condition: a low held long enough, judged as the line rises;
                    // tim_q lags the low length by one cycle
                    if (line_f && !line_q)
                    begin
                        if (tim_q >= 16'(pulse_sel_pkg::START_CYC - 1))
                        begin
                            st_d = ST_COUNT;
                            cnt_d = 6'h00;
                        end
                        else
                        begin
                            st_d = ST_IDLE;
                        end
                    end
                end
                ST_COUNT:
                begin
                    if (line_f && !line_q && cnt_q != 6'h3f)
                    begin
                        cnt_d = cnt_q + 6'h01;
                    end
                    if (line_f && tim_q >= 16'(pulse_sel_pkg::IDLE_CYC))
                    begin
                        // stop condition: apply only a legal count
                        st_d = ST_IDLE;
                        if (cnt_q != 6'h00 && cnt_q <= pulse_sel_pkg::COUNT_WIDE_MAX)
                        begin
                            prog_d = cnt_q[4:0];
                            prog_ok_d = 1'b1;
                        end
                        cnt_d = 6'h00;
                    end
                end
                default:
                begin
                    st_d = ST_IDLE;
                end
            endcase
        end
    end

    always_ff @(posedge i_clk or negedge i_rstn)
    begin
        if (!i_rstn)
        begin
            st_q <= ST_IDLE;
            line_q <= 1'b1;
            cnt_q <= 6'h00;
            tim_q <= 16'h0000;
            prog_q <= pulse_sel_pkg::COUNT_DEFAULT;
            prog_ok_q <= 1'b0;
        end
        else
        begin
            st_q <= st_d;
            line_q <= line_d;
            cnt_q <= cnt_d;
            tim_q <= tim_d;
            prog_q <= prog_d;
            prog_ok_q <= prog_ok_d;
        end
    end

    // ****************************************************************
    // power control and soft start sequence
    // ****************************************************************
    logic on_q;
    logic on_d;
    logic [4:0] code_q;
    logic [4:0] code_d;
    logic [12:0] mv_q;
    logic [12:0] mv_d;
    logic [pulse_sel_pkg::TCNT_W-1:0] ss_q;
    logic [pulse_sel_pkg::TCNT_W-1:0] ss_d;
    logic pos_q;
    logic pos_d;
    logic neg_q;
    logic neg_d;
    logic reg_q;
    logic reg_d;

    always_comb
    begin
        // both low turns the device off; the filtered line avoids glitching power
        on_d = link.enable | line_f;
        if (link.enable)
        begin
            code_d = pulse_sel_pkg::COUNT_DEFAULT;
        end
        else if (prog_ok_q)
        begin
            code_d = prog_q;
        end
        else
        begin
            code_d = pulse_sel_pkg::COUNT_DEFAULT;
        end
        mv_d = level_mv(code_d);
        ss_d = ss_q;
        pos_d = 1'b0;
        neg_d = 1'b0;
        reg_d = 1'b0;
        if (on_q)
        begin
            if (ss_q < pulse_sel_pkg::TCNT_W'(REG_DELAY))
            begin
                ss_d = ss_q + 1'b1;
            end
            pos_d = 1'b1;
            neg_d = ss_q >= pulse_sel_pkg::TCNT_W'(NEG_DELAY);
            reg_d = ss_q >= pulse_sel_pkg::TCNT_W'(REG_DELAY);
        end
        else
        begin
            ss_d = '0;
        end
    end

    always_ff @(posedge i_clk or negedge i_rstn)
    begin
        if (!i_rstn)
        begin
            on_q <= 1'b0;
            code_q <= pulse_sel_pkg::COUNT_DEFAULT;
            mv_q <= pulse_sel_pkg::LEVEL_DEFAULT_MV;
            ss_q <= '0;
            pos_q <= 1'b0;
            neg_q <= 1'b0;
            reg_q <= 1'b0;
        end
        else
        begin
            on_q <= on_d;
            code_q <= code_d;
            mv_q <= mv_d;
            ss_q <= ss_d;
            pos_q <= pos_d;
            neg_q <= neg_d;
            reg_q <= reg_d;
        end
    end

    assign o_device_on = on_q;
    assign o_pos_soft_start = pos_q;
    assign o_neg_soft_start = neg_q;
    assign o_regulating = reg_q;
    assign o_level_code = code_q;
    assign o_negative_rail_level = mv_q;
endmodule : pulse_sel_device

// ---- hdl/pulse_sel_master.sv ----
`timescale 1ns/1ps
module pulse_sel_master (
    input wire logic i_clk,
    input wire logic i_rstn,
    input wire logic i_req,
    input wire logic [4:0] i_count,
    input wire logic i_enable,
    input wire logic i_keep_on,
    output logic o_busy,
    pulse_link_if.master link
);
    typedef enum logic [1:0] {
        M_IDLE = 2'b00,
        M_START = 2'b01,
        M_PULSE = 2'b10,
        M_STOP = 2'b11
    } m_state_t;

    m_state_t st_q;
    m_state_t st_d;
    logic [15:0] tim_q;
    logic [15:0] tim_d;
    logic [4:0] left_q;
    logic [4:0] left_d;
    logic low_q;
    logic low_d;
    logic en_q;
    logic en_d;
    logic line_hi_q;
    logic line_hi_d;
    logic busy_q;
    logic busy_d;

    always_comb
    begin
        st_d = st_q;
        tim_d = tim_q + 16'h0001;
        left_d = left_q;
        low_d = 1'b0;
        // enable is held low during programming
        en_d = (st_q == M_IDLE && !i_req) ? i_enable : 1'b0;
        case (st_q)
            M_IDLE:
            begin
                low_d = !i_keep_on;
                tim_d = 16'h0000;
                if (i_req && i_count != 5'h00)
                begin
                    st_d = M_START;
                    left_d = i_count;
                    low_d = 1'b1;
                end
            end
            M_START:
            begin
                // hold low beyond the start time, then release high
                low_d = tim_q < 16'(pulse_sel_pkg::START_CYC + pulse_sel_pkg::GLITCH_CYC);
                if (tim_q >= 16'(pulse_sel_pkg::START_CYC + pulse_sel_pkg::GLITCH_CYC
                    + pulse_sel_pkg::HALF_CYC))
                begin
                    st_d = M_PULSE;
                    tim_d = 16'h0000;
                end
            end
            M_PULSE:
            begin
                // 2 us low, 2 us high keeps the rate at 250 kHz or below
                low_d = tim_q < 16'(pulse_sel_pkg::HALF_CYC);
                if (tim_q >= 16'(2 * pulse_sel_pkg::HALF_CYC - 1))
                begin
                    tim_d = 16'h0000;
                    left_d = left_q - 5'h01;
                    if (left_q == 5'h01)
                    begin
                        st_d = M_STOP;
                    end
                end
            end
            M_STOP:
            begin
                if (tim_q >= 16'(pulse_sel_pkg::IDLE_CYC + pulse_sel_pkg::HALF_CYC))
                begin
                    st_d = M_IDLE;
                end
            end
            default:
            begin
                st_d = M_IDLE;
            end
        endcase
        // outputs come straight from flip-flops
        line_hi_d = !low_d;
        busy_d = (st_d != M_IDLE);
    end

    always_ff @(posedge i_clk or negedge i_rstn)
    begin
        if (!i_rstn)
        begin
            st_q <= M_IDLE;
            tim_q <= 16'h0000;
            left_q <= 5'h00;
            low_q <= 1'b1;
            en_q <= 1'b0;
            line_hi_q <= 1'b0;
            busy_q <= 1'b0;
        end
        else
        begin
            st_q <= st_d;
            tim_q <= tim_d;
            left_q <= left_d;
            low_q <= low_d;
            en_q <= en_d;
            line_hi_q <= line_hi_d;
            busy_q <= busy_d;
        end
    end

    // the master is the only driver of the wire
    assign link.line_o = line_hi_q;
    assign link.line_oe = 1'b1;
    assign link.enable = en_q;
    assign o_busy = busy_q;
endmodule : pulse_sel_master

// ---- hdl/pulse_sel_pkg.sv ----
// Function
// - count n gives -5.4 V plus (n-1)*100 mV
// - default level equals count six, -4.9 V
// - enable low, line low: device off
// - enable low, line high: programmed level
// - enable high: default level, count ignored
// - master holds enable low while programming
// - falling edges glitch filtered before counting
// - master drives line; device never drives it
// - start before pulses, stop after them
// - master pulse rate at most 250 kHz
// - device decodes with internal timing only
// - soft starts: positive, negative 2 ms, regulating 6 ms
package pulse_sel_pkg;
    // ****************************************************************
    // levels
    // ****************************************************************
    localparam int unsigned CLK_HZ = 10000000;
    localparam logic [4:0] COUNT_MAX = 5'h1f;
    localparam logic [4:0] COUNT_DEFAULT = 5'h06;
    localparam logic [5:0] COUNT_WIDE_MAX = 6'h1f;
    // negative level in mV below zero; -5400 + (n-1)*100
    localparam logic [12:0] LEVEL_BASE_MV = 13'h1518;
    localparam logic [12:0] LEVEL_STEP_MV = 13'h0064;
    // level for the default count, held while in reset
    localparam logic [12:0] LEVEL_DEFAULT_MV = 13'h1324;
    // ****************************************************************
    // timing
    // ****************************************************************
    // low-pass on falling edge: a low shorter than this is a glitch
    localparam int unsigned GLITCH_NS = 500;
    localparam int unsigned GLITCH_CYC = (GLITCH_NS * (CLK_HZ / 1000000)) / 1000;
    // stop condition: line high for this long ends the frame
    localparam int unsigned IDLE_US = 50;
    localparam int unsigned IDLE_CYC = IDLE_US * (CLK_HZ / 1000000);
    // start condition: low longer than a pulse, before the first pulse
    localparam int unsigned START_US = 10;
    localparam int unsigned START_CYC = START_US * (CLK_HZ / 1000000);
    // master pulse half period at 250 kHz is 2 us
    localparam int unsigned HALF_NS = 2000;
    localparam int unsigned HALF_CYC = (HALF_NS * (CLK_HZ / 1000000) + 999) / 1000;
    localparam int unsigned NEG_DELAY_MS = 2;
    localparam int unsigned NEG_DELAY_CYC = NEG_DELAY_MS * (CLK_HZ / 1000);
    localparam int unsigned REG_DELAY_MS = 6;
    localparam int unsigned REG_DELAY_CYC = REG_DELAY_MS * (CLK_HZ / 1000);
    localparam int unsigned TCNT_W = 17;
endpackage : pulse_sel_pkg

// ---- test/pulse_count_voltage_select_tb.sv ----
`timescale 1ns/1ps
module pulse_count_voltage_select_tb;
    logic i_clk;
    logic i_rstn;
    logic i_req;
    logic [4:0] i_count;
    logic i_enable;
    logic i_keep_on;
    logic o_busy;
    logic on1, pss1, nss1, rg1;
    logic [4:0] code1, code2;
    logic [12:0] lvl1, lvl2;
    int n_fail, samples_checked, cyc, seed, prog, n, k;
    pulse_link_if link1 ();
    pulse_link_if link2 ();
    pulse_sel_master pulse_sel_master_inst (.i_clk(i_clk), .i_rstn(i_rstn), .i_req(i_req),
        .i_count(i_count), .i_enable(i_enable), .i_keep_on(i_keep_on), .o_busy(o_busy),
        .link(link1));
    pulse_sel_device #(.NEG_DELAY(20), .REG_DELAY(60)) pulse_sel_device_inst (.i_clk(i_clk),
        .i_rstn(i_rstn), .link(link1), .o_device_on(on1), .o_pos_soft_start(pss1),
        .o_neg_soft_start(nss1), .o_regulating(rg1), .o_level_code(code1),
        .o_negative_rail_level(lvl1));
    // second end is driven by hand so the master's own rules can be broken
    pulse_sel_device #(.NEG_DELAY(20), .REG_DELAY(60)) pulse_sel_device_fault_inst (
        .i_clk(i_clk), .i_rstn(i_rstn), .link(link2), .o_device_on(), .o_pos_soft_start(),
        .o_neg_soft_start(), .o_regulating(), .o_level_code(code2),
        .o_negative_rail_level(lvl2));
    pulse_sel_props pulse_sel_props_inst (.i_clk(i_clk),
        .i_rstn(i_rstn), .line_o(link1.line_o), .line_oe(link1.line_oe),
        .enable(link1.enable), .line(link1.line), .o_device_on(on1),
        .o_pos_soft_start(pss1), .o_neg_soft_start(nss1), .o_regulating(rg1),
        .o_level_code(code1), .o_negative_rail_level(lvl1));
    // ****************************************************************
    // checking
    // ****************************************************************
    task automatic stop_test;
        $display("comparisons %0d mismatches %0d", samples_checked, n_fail);
        if (n_fail == 0 && samples_checked > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask : stop_test
    task automatic chk_code(input logic [4:0] got_c, input logic [12:0] got_l, input int exp);
        logic [12:0] exp_l;
        exp_l = 13'(5400 - (exp - 1) * 100);
        samples_checked += 2;
        if (got_c !== 5'(exp))
        begin
            $display("wrong value t=%0t got %h exp %h", $time, got_c, 5'(exp));
            n_fail++;
        end
        if (got_l !== exp_l)
        begin
            $display("wrong value t=%0t got %h exp %h", $time, got_l, exp_l);
            n_fail++;
        end
    endtask : chk_code
    task automatic chk_bit(input logic got, input logic exp);
        samples_checked++;
        if (got !== exp)
        begin
            $display("wrong value t=%0t got %h exp %h", $time, got, exp);
            n_fail++;
        end
    endtask : chk_bit
    // ****************************************************************
    // stimulus
    // ****************************************************************
    task automatic send(input int cnt);
        int w;
        i_count = 5'(cnt);
        i_req = 1'b1;
        w = 0;
        do
        begin
            @(negedge i_clk);
            w++;
        end while (o_busy !== 1'b1 && w < 10);
        i_req = 1'b0;
        w = 0;
        while (o_busy !== 1'b0 && w < 3000)
        begin
            @(negedge i_clk);
            w++;
        end
        repeat (4) @(negedge i_clk);
    endtask : send
    task automatic raw_low(input int c);
        link2.line_o = 1'b0;
        repeat (c) @(negedge i_clk);
        link2.line_o = 1'b1;
    endtask : raw_low
    task automatic raw_frame(input int cnt, input bit glitch);
        raw_low(105);
        repeat (20) @(negedge i_clk);
        repeat (cnt)
        begin
            raw_low(20);
            repeat (8) @(negedge i_clk);
            if (glitch)
                raw_low(3);
            else
                repeat (3) @(negedge i_clk);
            repeat (9) @(negedge i_clk);
        end
        repeat (534) @(negedge i_clk);
    endtask : raw_frame
    initial
    begin
        i_clk = 1'b0;
        forever #50 i_clk = ~i_clk;
    end
    always @(posedge i_clk)
    begin
        cyc <= cyc + 1;
        if (cyc == 40000)
        begin
            n_fail++;
            stop_test();
        end
    end
    initial
    begin
        i_rstn = 1'b0;
        i_req = 1'b0;
        i_count = 5'h00;
        i_enable = 1'b0;
        i_keep_on = 1'b1;
        link2.line_oe = 1'b1;
        link2.line_o = 1'b1;
        link2.enable = 1'b0;
        n_fail = 0;
        samples_checked = 0;
        cyc = 0;
        seed = 32'h913dc140;
        prog = 6;
        repeat (8) @(negedge i_clk);
        i_rstn = 1'b1;
        @(negedge i_clk);
        chk_code(code1, lvl1, 6);
        $display("test reset done");
        for (k = 0; k < 6; k++)
        begin
            n = (k == 0) ? 1 : (k == 1) ? 31 : (($random(seed) & 32'h7fffffff) % 31) + 1;
            send(n);
            prog = n;
            chk_code(code1, lvl1, prog);
            chk_bit(on1, 1'b1);
        end
        send(0);
        chk_code(code1, lvl1, prog);
        $display("test programming done");
        i_enable = 1'b1;
        repeat (70) @(negedge i_clk);
        chk_code(code1, lvl1, 6);
        chk_bit(rg1, 1'b1);
        // the master drops enable for its own frame, so this count takes
        send(10);
        prog = 10;
        chk_code(code1, lvl1, 6);
        i_enable = 1'b0;
        repeat (4) @(negedge i_clk);
        chk_code(code1, lvl1, prog);
        $display("test enable done");
        i_keep_on = 1'b0;
        repeat (20) @(negedge i_clk);
        chk_bit(on1, 1'b0);
        chk_bit(rg1, 1'b0);
        // enable alone powers up from off: rails come up in order
        i_enable = 1'b1;
        repeat (10) @(negedge i_clk);
        chk_bit(pss1, 1'b1);
        chk_bit(nss1, 1'b0);
        repeat (20) @(negedge i_clk);
        chk_bit(nss1, 1'b1);
        chk_bit(rg1, 1'b0);
        repeat (40) @(negedge i_clk);
        chk_bit(rg1, 1'b1);
        chk_code(code1, lvl1, 6);
        i_enable = 1'b0;
        repeat (10) @(negedge i_clk);
        chk_bit(on1, 1'b0);
        i_keep_on = 1'b1;
        repeat (10) @(negedge i_clk);
        chk_bit(on1, 1'b1);
        $display("test on off done");
        raw_frame(3, 1'b1);
        chk_code(code2, lvl2, 3);
        raw_frame(33, 1'b0);
        chk_code(code2, lvl2, 3);
        link2.enable = 1'b1;
        raw_frame(9, 1'b0);
        chk_code(code2, lvl2, 6);
        link2.enable = 1'b0;
        repeat (4) @(negedge i_clk);
        chk_code(code2, lvl2, 3);
        $display("test fault end done");
        stop_test();
    end
endmodule : pulse_count_voltage_select_tb

// ---- test/pulse_sel_props.sv ----
`timescale 1ns/1ps
module pulse_sel_props #(
    parameter int unsigned NEG_DELAY = 20,
    parameter int unsigned REG_DELAY = 60
) (
    input wire logic i_clk,
    input wire logic i_rstn,
    input wire logic line_o,
    input wire logic line_oe,
    input wire logic enable,
    input wire logic line,
    input wire logic o_device_on,
    input wire logic o_pos_soft_start,
    input wire logic o_neg_soft_start,
    input wire logic o_regulating,
    input wire logic [4:0] o_level_code,
    input wire logic [12:0] o_negative_rail_level
);
    // ****************************************************************
    // enable-high cycle counter
    // ****************************************************************
    // saturates so a long enable never wraps back into the window
    logic [7:0] en_cnt_q;
    logic [7:0] en_cnt_d;
    always_comb
    begin
        en_cnt_d = en_cnt_q;
        if (!enable)
            en_cnt_d = 8'h00;
        else if (en_cnt_q != 8'hff)
            en_cnt_d = en_cnt_q + 8'h01;
    end
    always_ff @(posedge i_clk or negedge i_rstn)
    begin
        if (!i_rstn)
            en_cnt_q <= 8'h00;
        else
            en_cnt_q <= en_cnt_d;
    end
    // ****************************************************************
    // properties
    // ****************************************************************
    default clocking @(posedge i_clk); endclocking
    default disable iff (!i_rstn);
    level_map_a: assert property (
        o_negative_rail_level == 13'h1518 - 13'(o_level_code - 5'h01) * 13'h0064)
        else $error("rail level does not match level code");
    code_range_a: assert property (o_level_code != 5'h00)
        else $error("level code zero");
    default_level_a: assert property (enable [*3] |-> o_level_code == 5'h06)
        else $error("enable high but level code not default");
    off_state_a: assert property ((!enable && !line) [*8] |-> !o_device_on)
        else $error("device on with enable and line low");
    on_by_line_a: assert property ((!enable && line) [*4] |-> o_device_on)
        else $error("device off with line high");
    apply_on_idle_a: assert property (
        ($changed(o_level_code) && !enable && !$past(enable) && !$past(enable, 3))
        |-> line && $past(line, 8))
        else $error("level code changed without idle high line");
    master_only_a: assert property (line_oe && line == line_o)
        else $error("line not driven by master alone");
    neg_start_time_a: assert property (
        $rose(o_neg_soft_start) && enable
        |-> o_pos_soft_start && en_cnt_q >= 8'(NEG_DELAY - 1) && en_cnt_q <= 8'(NEG_DELAY + 3))
        else $error("negative soft start out of window");
    regulate_time_a: assert property (
        $rose(o_regulating) && enable
        |-> en_cnt_q >= 8'(REG_DELAY - 1) && en_cnt_q <= 8'(REG_DELAY + 3))
        else $error("regulation start out of window");
    cover property (enable && o_regulating);
endmodule : pulse_sel_props
